// >>> rtl/recorder_pkg.sv
// Purpose: Shared constants and types for the sample recorder
// Assumes: 125 MHz mclk, 32-bit Avalon-MM register bus, byte addresses
// Notes: Register offsets are byte addresses of aligned words
package recorder_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int DRIVE_PERIOD_NS = 62500;
    localparam int DRIVE_TICK_CYCLES = DRIVE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MAX_CHANNELS = 6;
    localparam int EXT_SOURCES = 8;
    localparam int SAMPLE_W = 16;
    localparam int PCT_FULL = 100;
    localparam logic [15:0] SAW_TOP = 16'h0009;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_KIND = 8'h08;
    localparam logic [7:0] OFS_THRESH = 8'h0c;
    localparam logic [7:0] OFS_POLARITY = 8'h10;
    localparam logic [7:0] OFS_PRETRIG = 8'h14;
    localparam logic [7:0] OFS_DECIM = 8'h18;
    localparam logic [7:0] OFS_DURATION = 8'h1c;
    localparam logic [7:0] OFS_TSRC = 8'h20;
    localparam logic [7:0] OFS_CHCFG = 8'h24;
    localparam logic [7:0] OFS_FETCH_PTR = 8'h40;
    localparam logic [7:0] OFS_FETCH_DATA = 8'h44;

    localparam int CTRL_ARM_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_TRIG_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    localparam int STAT_COUNT_LSB = 16;
    localparam int FETCH_CH_LSB = 16;

    localparam logic [15:0] RST_DECIM = 16'h0001;
    localparam logic [6:0] RST_PRETRIG = 7'h00;
    localparam logic [23:0] RST_DURATION = 24'h000400;
    localparam logic RST_POLARITY = 1'b1;

    typedef logic [SAMPLE_W-1:0] sample_type;
    typedef sample_type [EXT_SOURCES-1:0] ext_src_type;

    typedef enum logic [1:0] {
        KIND_IMMEDIATE = 2'h0,
        KIND_COMMAND = 2'h1,
        KIND_LEVEL = 2'h2,
        KIND_BOOLEAN = 2'h3
    } trig_kind_type;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DIV1 = 6'h02,
        ST_DIV2 = 6'h04,
        ST_PRE = 6'h08,
        ST_WAIT = 6'h10,
        ST_POST = 6'h20
    } state_type;

    typedef struct packed {
        logic [2:0] shift;
        logic filt;
        logic [3:0] src;
    } chan_cfg_type;

    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avm_req_type;
endpackage

// >>> rtl/sample_recorder.sv
// Purpose: Multi-channel sample recorder with trigger unit, Avalon-MM slave
// Assumes: Sources and command strobe come from logic on mclk
// Notes: Source code 0 none, 1 test sawtooth, 2+i external input i
//
// What this block does
// - Capture up to six channels at same instants
// - Source none collects no samples
// - Filter applied at capture, never retroactively
// - Sample count derived from duration and rate
// - Trigger kinds: immediate, command, level, boolean
// - Immediate kind starts capture upon arm
// - Command kind fires on next received command
// - Pretrigger percent of samples precede trigger
// - Pretrigger ignored for immediate kind
// - Threshold only for level; slope sets boolean polarity
// - Positive slope: below before, at/above now
// - Negative slope: above before, at/below now
// - Decimated pretrigger evaluates trigger every N samples
// - Zero pretrigger evaluates trigger every drive sample
// - Test source sawtooth zero to nine per tick
// - Fetch returns sample values only
// - Boolean kind acts on state, not edges
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sample_recorder #(
    parameter int CHANNELS = recorder_pkg::MAX_CHANNELS,
    parameter int DEPTH = 1024,
    parameter int TICK_CYCLES = recorder_pkg::DRIVE_TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire recorder_pkg::avm_req_type avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire recorder_pkg::ext_src_type ext_src,
    input wire logic cmd_strobe
);
    import recorder_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int RST_SPAN = RST_DURATION / RST_DECIM; // Count the reset settings imply

    if (CHANNELS < 1 || CHANNELS > MAX_CHANNELS || DEPTH < 4 || DEPTH > 32768 ||
        (DEPTH & (DEPTH - 1)) != 0 || TICK_CYCLES < 2) begin : g_bad_param
        $error("sample_recorder: unsupported parameter values");
    end

    function automatic sample_type sel_src(input logic [3:0] code, input sample_type saw,
                                           input ext_src_type ext);
        sample_type v = '0;
        if (code == 4'h1) begin
            v = saw;
        end else if (code >= 4'h2 && code < 4'(EXT_SOURCES + 2)) begin
            v = ext[code - 4'h2];
        end
        return v;
    endfunction

    function automatic logic [3:0] chan_slot(input logic [7:0] a);
        logic [7:0] d = a - OFS_CHCFG;
        chan_slot = {a >= OFS_CHCFG && d < 8'(4 * CHANNELS) && a[1:0] == 2'h0, d[4:2]};
    endfunction

    // Registers
    logic wait_r;
    logic [31:0] rdata_r;
    trig_kind_type kind_r;
    logic [15:0] thresh_r;
    logic pol_r;
    logic [6:0] pct_r;
    logic [15:0] decim_r;
    logic [23:0] dur_r;
    logic [3:0] tsrc_r;
    chan_cfg_type cfg_r [CHANNELS];
    logic [2:0] fetch_ch_r;
    logic [AW-1:0] fetch_idx_r;
    state_type state_r;
    logic [23:0] rem_r;
    logic [CW-1:0] q_r, total_r, pre_r, cnt_r;
    logic [AW-1:0] wr_ptr_r, start_r;
    logic trig_r, done_r, cmd_seen_r, prev_ok_r, tick_r;
    sample_type prev_r, saw_r;
    logic [31:0] tick_cnt_r;
    logic [15:0] dec_cnt_r;

    // Bus decode
    wire acc = (avs_req.read | avs_req.write) & ~wait_r;
    wire wr_acc = avs_req.write & ~wait_r;
    wire rd_load = avs_req.read & wait_r;
    wire [7:0] addr = avs_req.address;
    wire [31:0] wdata = avs_req.writedata;
    wire [3:0] wr_slot = chan_slot(addr);
    wire idle = (state_r == ST_IDLE);
    wire arm = wr_acc && addr == OFS_CTRL && wdata[CTRL_ARM_BIT] && idle;
    wire fetch_step = acc && avs_req.read && addr == OFS_FETCH_DATA;

    // Sample timing
    wire [15:0] decim_eff = (decim_r == 16'h0000) ? 16'h0001 : decim_r;
    wire rec_tick = tick_r && dec_cnt_r == 16'h0000;
    wire eval_stb = (pre_r == '0) ? tick_r : rec_tick;

    // Trigger unit
    wire [6:0] pct_eff = (kind_r == KIND_IMMEDIATE) ? 7'h00 :
                         (pct_r > 7'(PCT_FULL)) ? 7'(PCT_FULL) : pct_r;
    wire sample_type tval = sel_src(tsrc_r, saw_r, ext_src);
    wire signed [15:0] cur_s = tval;
    wire signed [15:0] prev_s = prev_r;
    wire signed [15:0] th_s = thresh_r;
    wire up_cross = prev_ok_r && prev_s < th_s && cur_s >= th_s;
    wire dn_cross = prev_ok_r && prev_s > th_s && cur_s <= th_s;
    logic trig_cond;
    always_comb begin
        case (kind_r)
            KIND_IMMEDIATE: trig_cond = 1'b1;
            KIND_COMMAND: trig_cond = cmd_seen_r | cmd_strobe;
            KIND_LEVEL: trig_cond = pol_r ? up_cross : dn_cross;
            default: trig_cond = (tval[0] == pol_r);
        endcase
    end
    wire wait_st = (state_r == ST_WAIT);
    wire hit_stb = wait_st && eval_stb && trig_cond;
    wire cap_stb = ((state_r == ST_PRE || state_r == ST_POST) && rec_tick) ||
                   (wait_st && ((pre_r == '0) ? hit_stb : rec_tick));
    wire [CW-1:0] post_len = total_r - pre_r;
    wire [CW-1:0] cnt_inc = cnt_r + CW'(1);

    // Divider helpers; pretrigger share holds back at least the trigger sample
    wire [CW-1:0] tot_c = (q_r == '0) ? CW'(1) : q_r;
    wire [23:0] prod = 24'(tot_c) * 24'(pct_eff);
    wire [CW-1:0] pre_c = (q_r >= total_r) ? total_r - CW'(1) : q_r;
    wire [AW-1:0] fin_start = wr_ptr_r + AW'(1) - total_r[AW-1:0];

    // Channel storage and filters
    sample_type ch_rd [CHANNELS];
    logic [CHANNELS-1:0] ch_on;
    for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
        sample_type mem [DEPTH];
        sample_type filt_r;
        wire sample_type x = sel_src(cfg_r[g].src, saw_r, ext_src);
        wire [16:0] diff = {x[15], x} - {filt_r[15], filt_r};
        wire [16:0] shd = $signed(diff) >>> cfg_r[g].shift;
        wire sample_type ynew = cfg_r[g].filt ? filt_r + shd[15:0] : x;
        assign ch_on[g] = (cfg_r[g].src != 4'h0);
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                filt_r <= '0;
            end else if (cap_stb) begin
                filt_r <= ynew;
            end
        end
        always_ff @(posedge mclk) begin
            if (cap_stb && ch_on[g]) begin
                mem[wr_ptr_r] <= ynew;
            end
        end
        assign ch_rd[g] = mem[start_r + fetch_idx_r];
    end

    // Read mux
    wire fetch_ok = fetch_ch_r < 3'(CHANNELS);
    wire sample_type fetch_val = (fetch_ok && ch_on[fetch_ch_r]) ? ch_rd[fetch_ch_r] : '0;
    logic [31:0] rd_val;
    always_comb begin
        rd_val = '0;
        if (addr == OFS_STATUS) begin
            rd_val[STAT_BUSY_BIT] = ~idle;
            rd_val[STAT_TRIG_BIT] = trig_r;
            rd_val[STAT_DONE_BIT] = done_r;
            rd_val[STAT_COUNT_LSB +: CW] = total_r;
        end else if (addr == OFS_KIND) begin
            rd_val[1:0] = kind_r;
        end else if (addr == OFS_THRESH) begin
            rd_val[15:0] = thresh_r;
        end else if (addr == OFS_POLARITY) begin
            rd_val[0] = pol_r;
        end else if (addr == OFS_PRETRIG) begin
            rd_val[6:0] = pct_r;
        end else if (addr == OFS_DECIM) begin
            rd_val[15:0] = decim_r;
        end else if (addr == OFS_DURATION) begin
            rd_val[23:0] = dur_r;
        end else if (addr == OFS_TSRC) begin
            rd_val[3:0] = tsrc_r;
        end else if (wr_slot[3]) begin
            rd_val[7:0] = cfg_r[wr_slot[2:0]];
        end else if (addr == OFS_FETCH_PTR) begin
            rd_val[FETCH_CH_LSB +: 3] = fetch_ch_r;
            rd_val[AW-1:0] = fetch_idx_r;
        end else if (addr == OFS_FETCH_DATA) begin
            rd_val = {{16{fetch_val[15]}}, fetch_val};
        end
    end

    // Bus slave: one wait state, answer on the second edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wait_r <= 1'b1;
            rdata_r <= '0;
        end else begin
            wait_r <= ~((avs_req.read | avs_req.write) & wait_r);
            if (rd_load) begin
                rdata_r <= rd_val;
            end
        end
    end
    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

    // Configuration registers; edits during a recording take effect at once, save duration, latched at arm, and pretrigger, read only in the division after arm
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            kind_r <= KIND_IMMEDIATE;
            thresh_r <= '0;
            pol_r <= RST_POLARITY;
            pct_r <= RST_PRETRIG;
            decim_r <= RST_DECIM;
            dur_r <= RST_DURATION;
            tsrc_r <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                cfg_r[i] <= '0;
            end
            fetch_ch_r <= '0;
            fetch_idx_r <= '0;
        end else if (wr_acc) begin
            if (addr == OFS_KIND) begin
                kind_r <= trig_kind_type'(wdata[1:0]);
            end else if (addr == OFS_THRESH) begin
                thresh_r <= wdata[15:0];
            end else if (addr == OFS_POLARITY) begin
                pol_r <= wdata[0];
            end else if (addr == OFS_PRETRIG) begin
                pct_r <= wdata[6:0];
            end else if (addr == OFS_DECIM) begin
                decim_r <= wdata[15:0];
            end else if (addr == OFS_DURATION) begin
                dur_r <= wdata[23:0];
            end else if (addr == OFS_TSRC) begin
                tsrc_r <= wdata[3:0];
            end else if (wr_slot[3]) begin
                cfg_r[wr_slot[2:0]] <= wdata[7:0];
            end else if (addr == OFS_FETCH_PTR) begin
                fetch_ch_r <= wdata[FETCH_CH_LSB +: 3];
                fetch_idx_r <= wdata[AW-1:0];
            end
        end else if (fetch_step) begin
            fetch_idx_r <= fetch_idx_r + AW'(1);
        end
    end

    // Drive sample tick, test sawtooth, decimation
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
            saw_r <= '0;
            dec_cnt_r <= '0;
        end else begin
            tick_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
            tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 32'h1;
            if (tick_r) begin
                saw_r <= (saw_r == SAW_TOP) ? '0 : saw_r + 16'h1;
            end
            if (arm) begin
                dec_cnt_r <= '0;
            end else if (hit_stb && pre_r == '0) begin
                dec_cnt_r <= (decim_eff == 16'h1) ? '0 : 16'h1;
            end else if (tick_r) begin
                dec_cnt_r <= (dec_cnt_r == decim_eff - 16'h1) ? '0 : dec_cnt_r + 16'h1;
            end
        end
    end

    // Recording sequence
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            rem_r <= '0;
            q_r <= '0;
            total_r <= CW'((RST_SPAN > DEPTH) ? DEPTH : RST_SPAN);
            pre_r <= '0;
            cnt_r <= '0;
            wr_ptr_r <= '0;
            start_r <= '0;
            trig_r <= 1'b0;
            done_r <= 1'b0;
            cmd_seen_r <= 1'b0;
            prev_ok_r <= 1'b0;
            prev_r <= '0;
        end else begin
            if (cap_stb) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (wait_st && eval_stb) begin
                prev_r <= tval;
                prev_ok_r <= 1'b1;
            end
            cmd_seen_r <= wait_st && (cmd_seen_r | cmd_strobe);
            case (state_r)
                ST_IDLE: begin
                    if (arm) begin
                        rem_r <= dur_r;
                        q_r <= '0;
                        done_r <= 1'b0;
                        trig_r <= 1'b0;
                        state_r <= ST_DIV1;
                    end
                end
                ST_DIV1: begin
                    if (rem_r >= 24'(decim_eff) && q_r < CW'(DEPTH)) begin
                        rem_r <= rem_r - 24'(decim_eff);
                        q_r <= q_r + CW'(1);
                    end else begin
                        total_r <= tot_c;
                        rem_r <= prod;
                        q_r <= '0;
                        state_r <= ST_DIV2;
                    end
                end
                ST_DIV2: begin
                    if (rem_r >= 24'(PCT_FULL)) begin
                        rem_r <= rem_r - 24'(PCT_FULL);
                        q_r <= q_r + CW'(1);
                    end else begin
                        pre_r <= pre_c;
                        cnt_r <= '0;
                        prev_ok_r <= 1'b0;
                        state_r <= (pre_c == '0) ? ST_WAIT : ST_PRE;
                    end
                end
                ST_PRE: begin
                    if (cap_stb) begin
                        cnt_r <= cnt_inc;
                        if (cnt_inc == pre_r) begin
                            state_r <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (hit_stb) begin
                        trig_r <= 1'b1;
                        cnt_r <= CW'(1);
                        if (post_len == CW'(1)) begin
                            start_r <= fin_start;
                            done_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end else begin
                            state_r <= ST_POST;
                        end
                    end
                end
                ST_POST: begin
                    if (cap_stb) begin
                        cnt_r <= cnt_inc;
                        if (cnt_inc == post_len) begin
                            start_r <= fin_start;
                            done_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> tb/sample_recorder_sva.sv
// Purpose: Bus and readback checks on the recorder ports
// Assumes: One wait state per access, as handed over
// Notes: Sees only the top module ports
`timescale 1ns/1ns
`default_nettype none
module sample_recorder_sva #(
    parameter int CHANNELS = 6,
    parameter int DEPTH = 1024,
    parameter int TICK_CYCLES = 7812
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire recorder_pkg::avm_req_type avs_req,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire recorder_pkg::ext_src_type ext_src,
    input wire logic cmd_strobe
);
    import recorder_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_req;
        (avs_req.read || avs_req.write) && avs_waitrequest;
    endsequence
    sequence s_rd(logic [7:0] a);
        avs_req.read && avs_req.address == a && avs_waitrequest;
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> !avs_waitrequest)
        else $error("request not answered one cycle later");
    AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_ACK_CAUSE: assert property ($fell(avs_waitrequest) |-> $past(avs_req.read || avs_req.write))
        else $error("answer without request");
    AST_RDATA_HOLD: assert property (!(avs_req.read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    AST_CTRL_RD0: assert property (s_rd(OFS_CTRL) |=> avs_readdata == 32'h0)
        else $error("control word does not read zero");
    AST_FETCH_SEXT: assert property (s_rd(OFS_FETCH_DATA) |=> avs_readdata[31:16] == {16{avs_readdata[15]}})
        else $error("fetched sample is not a plain sign-extended value");
    AST_COUNT_RANGE: assert property (s_rd(OFS_STATUS) |=> avs_readdata[26:16] != 0 && avs_readdata[26:16] <= DEPTH)
        else $error("sample count out of range");
    AST_DONE_TRIG: assert property (s_rd(OFS_STATUS) |=> avs_readdata[2] -> (avs_readdata[1] && !avs_readdata[0]))
        else $error("done without trigger or while busy");
    AST_KIND_FIELD: assert property (s_rd(OFS_KIND) |=> avs_readdata[31:2] == 30'h0)
        else $error("trigger kind wider than two bits");
    AST_POL_FIELD: assert property (s_rd(OFS_POLARITY) |=> avs_readdata[31:1] == 31'h0)
        else $error("polarity wider than one bit");
endmodule
bind sample_recorder sample_recorder_sva #(.CHANNELS(CHANNELS), .DEPTH(DEPTH),
    .TICK_CYCLES(TICK_CYCLES)) i_sample_recorder_sva (.mclk(mclk), .rstn(rstn),
    .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_src(ext_src), .cmd_strobe(cmd_strobe));
`default_nettype wire

// >>> tb/recorder_host.sv
// Purpose: Host software side, a plain Avalon-MM master
// Assumes: Called right after a rising edge
// Notes: Ends one edge after the answer so no signal is set twice at once
`timescale 1ns/1ns
`default_nettype none
module recorder_host (
    input wire logic mclk,
    output var recorder_pkg::avm_req_type avs_req,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    import recorder_pkg::*;
    initial avs_req = '0;
    // Configure, arm and fetch all go through here, one at a time
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        avs_req <= '{address: a, read: !w, write: w, writedata: d};
        do @(posedge mclk); while (avs_waitrequest);
        q = avs_readdata;
        avs_req <= '0;
        @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// >>> tb/sample_recorder_tb.sv
// Purpose: Self-checking bench for the sample recorder
// Assumes: Short drive tick and shallow depth to keep runs brief
// Notes: Expected read values queue up; a monitor pops one per read
`timescale 1ns/1ns
`default_nettype none
module sample_recorder_tb;
    import recorder_pkg::*;
    logic mclk, rstn, cmd_strobe;
    avm_req_type avs_req;
    logic [31:0] avs_readdata, v, r;
    logic avs_waitrequest;
    ext_src_type ext_src;
    logic [32:0] expq [$];
    int n_errors = 0;
    int tests_run = 0;
    int seed = 32'hcd1e;
    int i, e_f;
    logic [7:0] ofs [0:11] = '{OFS_CTRL, OFS_STATUS, OFS_KIND, OFS_THRESH, OFS_POLARITY,
        OFS_PRETRIG, OFS_DECIM, OFS_DURATION, OFS_TSRC, OFS_CHCFG, OFS_FETCH_PTR, 8'hfc};
    logic [31:0] rv [0:11] = '{32'h0, 32'h00100000, 32'h0, 32'h0, 32'h1, 32'h0, 32'h1,
        32'h400, 32'h0, 32'h0, 32'h0, 32'h0};
    sample_recorder #(.CHANNELS(6), .DEPTH(16), .TICK_CYCLES(4)) i_sample_recorder (
        .mclk(mclk), .rstn(rstn), .avs_req(avs_req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_src(ext_src), .cmd_strobe(cmd_strobe));
    recorder_host i_recorder_host (.mclk(mclk), .avs_req(avs_req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    always @(posedge mclk) begin
        logic [32:0] e;
        if (avs_req.read && !avs_waitrequest && expq.size() > 0) begin
            e = expq.pop_front();
            if (e[32]) check(avs_readdata, e[31:0]);
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_recorder_host.xfer(1'b1, a, d, v);
    endtask
    // Bit 32 of the note says whether the value is compared at all
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        i_recorder_host.xfer(1'b0, a, 32'h0, v);
    endtask
    task automatic st(input logic [31:0] e);
        rd(OFS_STATUS, {1'b1, e});
    endtask
    task automatic wait_done;
        repeat (100) begin
            rd(OFS_STATUS, 33'h0);
            if (v[STAT_DONE_BIT]) break;
        end
    endtask
    task automatic rec(input logic [1:0] k, input int th, input int pol, input int pct,
                       input int dec, input int dur);
        wr(OFS_KIND, {30'h0, k});
        wr(OFS_THRESH, 32'(th));
        wr(OFS_POLARITY, 32'(pol));
        wr(OFS_PRETRIG, 32'(pct));
        wr(OFS_DECIM, 32'(dec));
        wr(OFS_DURATION, 32'(dur));
        wr(OFS_CTRL, 32'h1);
    endtask
    // A first value below the sample range means the sawtooth phase is unknown: take it, then step
    task automatic chk_ch(input int ch, input int n, input int first, input int step);
        int e;
        e = first;
        wr(OFS_FETCH_PTR, 32'(ch << FETCH_CH_LSB));
        if (first < -32768) begin
            rd(OFS_FETCH_DATA, 33'h0);
            e = (int'(v) + step) % 10;
            n--;
        end
        repeat (n) begin
            rd(OFS_FETCH_DATA, {1'b1, 32'(e)});
            e = (step == 0) ? e : (e + step) % 10;
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Eight recordings of under two hundred cycles each, with wide margin
    initial begin
        repeat (30000) @(posedge mclk);
        n_errors++;
        tally_and_finish;
    end
    initial begin
        rstn = 1'b0;
        cmd_strobe = 1'b0;
        ext_src = '0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        for (i = 0; i < 12; i++) begin
            rd(ofs[i], {1'b1, rv[i]});
        end
        $display("test reset values done");
        for (i = 0; i < 4; i++) begin
            wr(OFS_KIND, 32'(i));
            rd(OFS_KIND, {1'b1, 32'(i)});
        end
        r = 32'($random(seed)) & 32'h7fff;
        wr(OFS_THRESH, r);
        rd(OFS_THRESH, {1'b1, r});
        $display("test kinds done");
        ext_src[1] <= 16'($random(seed));
        wr(OFS_CHCFG, 32'h1);
        wr(OFS_CHCFG + 8'h04, 32'h3);
        rec(KIND_IMMEDIATE, 0, 1, 50, 1, 10);
        wait_done;
        st(32'h000a0006);
        chk_ch(0, 10, -65536, 1);
        chk_ch(1, 10, int'($signed(ext_src[1])), 0);
        chk_ch(2, 3, 0, 0);
        chk_ch(6, 2, 0, 0);
        wr(OFS_CHCFG + 8'h04, 32'h33);
        chk_ch(1, 2, int'($signed(ext_src[1])), 0);
        wr(OFS_CHCFG + 8'h08, 32'h33);
        rec(KIND_IMMEDIATE, 0, 1, 0, 2, 10);
        wait_done;
        st(32'h00050006);
        chk_ch(0, 5, -65536, 2);
        wr(OFS_FETCH_PTR, 32'(2 << FETCH_CH_LSB));
        e_f = 0;
        repeat (5) begin
            e_f = e_f + ((int'($signed(ext_src[1])) - e_f) >>> 1);
            rd(OFS_FETCH_DATA, {1'b1, 32'(e_f)});
        end
        $display("test immediate done");
        wr(OFS_TSRC, 32'h1);
        rec(KIND_LEVEL, 3, 1, 0, 1, 4);
        wait_done;
        chk_ch(0, 4, 3, 1);
        rec(KIND_LEVEL, 3, 0, 0, 1, 4);
        wait_done;
        chk_ch(0, 4, 0, 1);
        rec(KIND_LEVEL, 3, 1, 50, 1, 4);
        wait_done;
        chk_ch(0, 4, 1, 1);
        $display("test level done");
        wr(OFS_TSRC, 32'h2);
        ext_src[0] <= 16'h0001;
        rec(KIND_BOOLEAN, 32'h7fff, 1, 0, 1, 4);
        wait_done;
        st(32'h00040006);
        rec(KIND_BOOLEAN, 0, 0, 0, 1, 4);
        repeat (40) @(posedge mclk);
        st(32'h00040001);
        ext_src[0] <= 16'h0002;
        wait_done;
        st(32'h00040006);
        $display("test boolean done");
        rec(KIND_COMMAND, 0, 1, 0, 1, 4);
        repeat (40) @(posedge mclk);
        st(32'h00040001);
        cmd_strobe <= 1'b1;
        @(posedge mclk);
        cmd_strobe <= 1'b0;
        wait_done;
        st(32'h00040006);
        $display("test command done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
